// ===== pkg/serial_port_defs.vh
// constants for the serial host slave port
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH
// framing codes
`define FRAME_MSB 2'h0
`define FRAME_LSB 2'h1
`define FRAME_SCI 2'h2
// sync bytes returned during address and control bytes, then the idle byte
`define SYNC_ADDR 8'haa
`define SYNC_CTRL 8'h55
`define IDLE_TX 8'hff
// init sequence byte values
`define INIT_ZERO 8'h00
`define INIT_ONES 8'hff
// control byte direction bit
`define CTRL_DIR_BIT 7
// address space
`define ADDR_LAST 8'hff
`define ADDR_CMD 8'h03
`define GLOBAL_RESET_CMD_BIT 7
`define ADDR_INT_LO 8'h08
`define ADDR_INT_HI 8'h0b
`define ADDR_MSG_BASE 8'h80
// internal reset hold, crystal clock periods
`define RST_WAIT_CYC 4'hc
// interrupt release width in crystal clock cycles, sized for rel_cnt
`define INT_REL_CYC 4'h1
`endif

// ===== testbench/serial_host_slave_port_assertions.sv
// assertions on the ports of the serial host slave port
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module serial_host_slave_port_checker (
	input wire mclk,
	input wire nrst,
	input wire ss_n,
	input wire reset_pin_n,
	input wire irq_pending,
	input wire miso_oe,
	input wire int_o,
	input wire int_oe,
	input wire rd_strobe,
	input wire [1:0] framing,
	input wire core_rst_n,
	input wire osc_en
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	// low time of the internal reset; saturates so it never wraps
	reg [4:0] low_cnt = 5'h0;
	always @(posedge mclk) begin
		if (core_rst_n)
			low_cnt <= 5'h0;
		else if (low_cnt != 5'h1f)
			low_cnt <= low_cnt + 5'h1;
	end
	property p_rst_len; $rose(core_rst_n) |-> low_cnt >= 5'hc; endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset short");
	property p_oe_off; ss_n [*4] |-> !miso_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("miso driven");
	property p_int_rel; $fell(int_oe) && irq_pending && core_rst_n
		|=> int_oe || !irq_pending; endproperty
	a_int_rel: assert property (p_int_rel) else $error("long release");
	property p_int_low; int_oe |-> !int_o && irq_pending; endproperty
	a_int_low: assert property (p_int_low) else $error("int high");
	property p_osc; !core_rst_n |-> osc_en; endproperty
	a_osc: assert property (p_osc) else $error("osc off");
	property p_strobe; rd_strobe |=> !rd_strobe; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe long");
	property p_dflt; $rose(nrst) |-> framing == `FRAME_MSB; endproperty
	a_dflt: assert property (p_dflt) else $error("framing not msb");
	property p_pin; !reset_pin_n [*5] |-> !core_rst_n && framing == 2'h0;
	endproperty
	a_pin: assert property (p_pin) else $error("pin reset lost");
	c_read: cover property (rd_strobe);
	c_sci: cover property (framing == `FRAME_SCI);
	c_rel: cover property ($fell(int_oe) && irq_pending);
endmodule // serial_host_slave_port_checker
bind serial_host_slave_port serial_host_slave_port_checker
	serial_host_slave_port_checker_i (.mclk, .nrst, .ss_n, .reset_pin_n,
	.irq_pending, .miso_oe, .int_o, .int_oe, .rd_strobe, .framing,
	.core_rst_n, .osc_en);

// ===== testbench/serial_host_slave_port_tb.sv
// self-checking bench for the serial host slave port
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module serial_host_slave_port_tb;
	reg mclk = 1'b0;
	reg nrst = 1'b0;
	reg reset_pin_n = 1'b1;
	reg irq_pending = 1'b0;
	reg wr_ready = 1'b1;
	reg [7:0] rd_data = 8'h00;
	reg [7:0] rx_msg_len = 8'h07;
	wire sclk, ss_n, mosi, miso, miso_oe, int_o, int_oe, rd_strobe;
	wire wr_valid, wr_drop, core_rst_n, osc_en;
	wire [7:0] rd_addr, wr_addr, wr_data;
	wire [1:0] framing;
	wire miso_w = miso_oe ? miso : 1'b1; // released line rests at pull-up
	integer num_errors = 0, checks = 0, drops = 0, rels = 0, rsts = 0;
	integer m, r;
	reg rst_q = 1'b0;
	reg [8:0] rx;
	reg [1:0] fr = 2'h0;
	reg [15:0] popped [$];
	serial_host_slave_port serial_host_slave_port_i (.mclk, .nrst, .sclk,
		.ss_n, .mosi, .miso, .miso_oe, .reset_pin_n, .irq_pending, .int_o,
		.int_oe, .rd_addr, .rd_strobe, .rd_data, .rx_msg_len, .wr_addr,
		.wr_data, .wr_valid, .wr_ready, .wr_drop, .framing, .core_rst_n,
		.osc_en);
	spi_host_model spi_host_model_i (.sclk, .ss_n, .mosi, .miso_w);
	initial forever #20 mclk = ~mclk;
	// core stand-in: read data, write sink and event counters
	always @(posedge mclk) begin
		rd_data <= rd_addr ^ 8'h5a;
		if (wr_valid && wr_ready) popped.push_back({wr_addr, wr_data});
		if (wr_drop) drops <= drops + 1;
		if (irq_pending && !int_oe && core_rst_n) rels <= rels + 1;
		if (rst_q && !core_rst_n) rsts <= rsts + 1;
		rst_q <= core_rst_n;
	end
	////////////////////////////////////////////////////////////////
	task chk(input string what, input [15:0] exp, input [15:0] got);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("mismatch %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task chk_pop(input [7:0] a, input [7:0] d);
		chk("write", {a, d}, popped.size() ? popped.pop_front() : 16'hxxxx);
	endtask
	// one frame: address, control, n data bytes; n < 0 skips sync checks
	task frame(input [7:0] a, input [7:0] c, input [7:0] d, input integer n);
		integer k;
		reg [7:0] e;
		begin
			@(posedge mclk);
			#7 spi_host_model_i.select(1'b0);
			spi_host_model_i.xfer(a, fr, rx);
			if (n >= 0) chk("sync a", {fr == `FRAME_SCI, `SYNC_ADDR}, rx);
			spi_host_model_i.xfer(c, fr, rx);
			if (n >= 0) chk("sync c", {fr == `FRAME_SCI, `SYNC_CTRL}, rx);
			for (k = 0; k < n; k = k + 1) begin
				spi_host_model_i.xfer(d + k[7:0], fr, rx);
				e = ((a + k > 255) ? 8'hff : a + k[7:0]) ^ 8'h5a;
				if (a >= `ADDR_MSG_BASE) e = rx_msg_len;
				if (!c[`CTRL_DIR_BIT] && (k == 0 || a < `ADDR_MSG_BASE))
					chk("read", {fr == `FRAME_SCI, e}, rx);
			end
			spi_host_model_i.select(1'b1);
			repeat (4) @(posedge mclk);
		end
	endtask
	task stop_test;
		begin
			$display("errors %0d checks %0d", num_errors, checks);
			if (num_errors == 0 && checks > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		num_errors = num_errors + 1;
		$display("mismatch watchdog expected end seen hang");
		stop_test;
	end
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (14) @(posedge mclk);
		chk("framing", `FRAME_MSB, framing);
		// clocks while deselected: line stays released, nothing shifts
		spi_host_model_i.xfer(8'h00, fr, rx);
		chk("idle line", 16'h00ff, rx);
		frame(8'hfe, 8'he0, 8'ha1, 3);
		chk_pop(8'hfe, 8'ha1);
		chk_pop(8'hff, 8'ha2);
		chk_pop(8'hff, 8'ha3);
		frame(8'hfe, 8'h60, 8'h00, 3);
		frame(8'h90, 8'h60, 8'h00, 1);
		// core stalls: two entries held, the third is lost
		wr_ready <= 1'b0;
		frame(8'h10, 8'he0, 8'hc0, 3);
		chk("drops", 1, drops);
		wr_ready <= 1'b1;
		repeat (4) @(posedge mclk);
		chk_pop(8'h10, 8'hc0);
		chk_pop(8'h11, 8'hc1);
		chk("left", 0, popped.size());
		irq_pending <= 1'b1;
		repeat (4) @(posedge mclk);
		r = rels;
		frame(8'h09, 8'he0, 8'h00, 1);
		chk("release", r + 1, rels);
		irq_pending <= 1'b0;
		r = rsts;
		frame(8'h03, 8'he0, 8'h80, 1);
		chk("command reset", r + 1, rsts);
		popped.delete();
		// each init pair picks a framing, then an access in it
		for (m = 0; m < 3; m = m + 1) begin
			r = rsts;
			frame(m == 1 ? 8'hff : 8'h00, m == 0 ? 8'h00 : 8'hff, 8'h00, -1);
			repeat (16) @(posedge mclk);
			chk("init reset", r + 1, rsts);
			fr = m == 0 ? `FRAME_MSB : m == 1 ? `FRAME_LSB : `FRAME_SCI;
			chk("framing", fr, framing);
			frame(8'h20, 8'h60, 8'hff, 1);
			frame(8'h40, 8'he0, 8'h3c, 1);
			chk_pop(8'h40, 8'h3c);
		end
		reset_pin_n <= 1'b0;
		repeat (6) @(posedge mclk);
		reset_pin_n <= 1'b1;
		repeat (20) @(posedge mclk);
		chk("framing", `FRAME_MSB, framing);
		fr = `FRAME_MSB;
		frame(8'h21, 8'h60, 8'h00, 1);
		stop_test;
	end
endmodule // serial_host_slave_port_tb

// ===== testbench/spi_host_model.sv
// host master model: drives serial clock, select and data in
`timescale 1ns/1ps
`include "serial_port_defs.vh"
module spi_host_model (
	output reg sclk,
	output reg ss_n,
	output reg mosi,
	input wire miso_w
);
	// clock idles high in every framing
	initial begin
		sclk = 1'b1;
		ss_n = 1'b1;
		mosi = 1'b0;
	end
	// select is held across the frame; the wait keeps the character gap
	task select(input b);
		begin
			ss_n = b;
			#480;
		end
	endtask
	// one character; sci runs at its own rate with a ninth clock
	task xfer(input [7:0] tx, input [1:0] fr, output [8:0] rx);
		integer i;
		integer j;
		integer hp;
		begin
			hp = (fr == `FRAME_SCI) ? 4000 : 160;
			rx = 9'h0;
			for (i = 0; i < ((fr == `FRAME_SCI) ? 9 : 8); i = i + 1) begin
				j = (fr == `FRAME_MSB) ? 7 - i : i;
				sclk = 1'b0;
				mosi = (i == 8) ? ~tx[7] : tx[j];
				#hp sclk = 1'b1;
				#(hp - 10) rx[j] = miso_w;
				#10;
			end
			mosi = ~mosi; // no stale copy of the last bit
			#480;
		end
	endtask
endmodule // spi_host_model

// ===== verilog/serial_host_slave_port.v
// serial host slave port: spi msb/lsb and 9-bit sci framings
`timescale 1ns/1ps
`include "serial_port_defs.vh"

module serial_host_slave_port #(
	parameter WR_DEPTH = 2
) (
	input wire mclk,
	input wire nrst,
	input wire sclk,
	input wire ss_n,
	input wire mosi,
	output reg miso,
	output wire miso_oe,
	input wire reset_pin_n,
	input wire irq_pending,
	output wire int_o,
	output wire int_oe,
	output reg [7:0] rd_addr,
	output reg rd_strobe,
	input wire [7:0] rd_data,
	input wire [7:0] rx_msg_len,
	output wire [7:0] wr_addr,
	output wire [7:0] wr_data,
	output wire wr_valid,
	input wire wr_ready,
	output reg wr_drop,
	output reg [1:0] framing,
	output wire core_rst_n,
	output wire osc_en
);

////////////////////////////////////////////////////////////////////////
// input synchronisers, each pin passes two flops first
wire sclk_q;
wire ss_q;
wire mosi_q;
wire pin_q;
reg sclk_d;

// clock, select and reset pin reset to their idle highs: no false edge
two_flop_sync #(.RESET_VAL(1'b1)) sclk_sync_i (
	.mclk(mclk),
	.nrst(nrst),
	.d(sclk),
	.q(sclk_q)
);
two_flop_sync #(.RESET_VAL(1'b1)) ss_sync_i (
	.mclk(mclk),
	.nrst(nrst),
	.d(ss_n),
	.q(ss_q)
);
two_flop_sync #(.RESET_VAL(1'b0)) mosi_sync_i (
	.mclk(mclk),
	.nrst(nrst),
	.d(mosi),
	.q(mosi_q)
);
two_flop_sync #(.RESET_VAL(1'b1)) pin_sync_i (
	.mclk(mclk),
	.nrst(nrst),
	.d(reset_pin_n),
	.q(pin_q)
);

// last synchronised clock level, for edge detection
always @(posedge mclk) begin
	if (!nrst) begin
		sclk_d <= 1'b1;
	end else begin
		sclk_d <= sclk_q;
	end
end

// clock idles high; data changes on falling, sampled on rising edge
wire sel = ~ss_q;
wire rise = sel & sclk_q & ~sclk_d;
wire fall = sel & ~sclk_q & sclk_d;
wire sci = (framing == `FRAME_SCI);
wire msb_first = (framing == `FRAME_MSB);
wire [3:0] last_bit = sci ? 4'h8 : 4'h7;

////////////////////////////////////////////////////////////////////////
// bit and byte counters, receive shifter
reg [3:0] bit_cnt;
reg [7:0] rx_sh;
reg [7:0] byte_idx;
reg [7:0] first_byte;
reg dir_wr;
reg [7:0] addr;
wire byte_done = rise & (bit_cnt == last_bit);
wire [7:0] rx_full = msb_first ? {rx_sh[6:0], mosi_q} :
	{mosi_q, rx_sh[7:1]};
// in sci the ninth bit completes the byte but is not shifted in
wire [7:0] rx_byte = (bit_cnt == 4'h8) ? rx_sh : rx_full;
wire is_ctrl = (byte_idx == 8'h01);
wire init_ctrl = (rx_byte == `INIT_ZERO) | (rx_byte == `INIT_ONES);
wire init_seq = byte_done & is_ctrl & init_ctrl;
wire data_byte = byte_done & (byte_idx >= 8'h02);

// a deselect restarts framing, so a lost clock resyncs at next frame
always @(posedge mclk) begin
	if (!nrst) begin
		bit_cnt <= 4'h0;
		rx_sh <= 8'h00;
		byte_idx <= 8'h00;
		first_byte <= 8'h00;
		dir_wr <= 1'b0;
	end else if (!sel) begin
		bit_cnt <= 4'h0;
		byte_idx <= 8'h00;
	end else if (rise) begin
		if (bit_cnt < 4'h8) begin
			rx_sh <= rx_full;
		end
		if (byte_done) begin
			bit_cnt <= 4'h0;
			if (byte_idx != 8'hff) begin
				byte_idx <= byte_idx + 8'h01;
			end
			if (byte_idx == 8'h00) begin
				first_byte <= rx_byte;
			end
			if (is_ctrl) begin
				dir_wr <= rx_byte[`CTRL_DIR_BIT];
			end
		end else begin
			bit_cnt <= bit_cnt + 4'h1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// address pointer: loaded from first byte, steps after each data byte, holds at ADDR_LAST
wire ctrl_ok = byte_done & is_ctrl & ~init_ctrl;
always @(posedge mclk) begin
	if (!nrst) begin
		addr <= 8'h00;
	end else if (ctrl_ok) begin
		addr <= first_byte;
	end else if (data_byte && addr != `ADDR_LAST) begin
		addr <= addr + 8'h01;
	end
end

////////////////////////////////////////////////////////////////////////
// framing selection: msb after hardware reset, init pair chooses
always @(posedge mclk) begin
	if (!nrst || !pin_q) begin
		framing <= `FRAME_MSB;
	end else if (init_seq) begin
		if (first_byte == `INIT_ZERO && rx_byte == `INIT_ZERO) begin
			framing <= `FRAME_MSB;
		end else if (first_byte == `INIT_ONES && rx_byte == `INIT_ONES) begin
			framing <= `FRAME_LSB;
		end else if (first_byte == `INIT_ZERO) begin
			framing <= `FRAME_SCI;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// read requests: after control byte and after each read data byte
reg rd_wait;
reg first_read;
wire rd_go = (ctrl_ok & ~rx_byte[`CTRL_DIR_BIT]) |
	(data_byte & ~dir_wr);
always @(posedge mclk) begin
	if (!nrst) begin
		rd_addr <= 8'h00;
		rd_strobe <= 1'b0;
		rd_wait <= 1'b0;
		first_read <= 1'b0;
	end else begin
		rd_strobe <= 1'b0;
		rd_wait <= rd_strobe;
		if (rd_go) begin
			rd_strobe <= 1'b1;
			first_read <= ctrl_ok;
			if (ctrl_ok) begin
				rd_addr <= first_byte;
			end else if (addr != `ADDR_LAST) begin
				rd_addr <= addr + 8'h01;
			end else begin
				rd_addr <= addr;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////
// transmit byte: sync pattern, then read data or idle ones
reg [7:0] tx_byte;
always @(posedge mclk) begin
	if (!nrst) begin
		tx_byte <= `SYNC_ADDR;
	end else if (!sel) begin
		tx_byte <= `SYNC_ADDR;
	end else if (rd_wait) begin
		// message memory opens with its length byte
		if (first_read && rd_addr >= `ADDR_MSG_BASE) begin
			tx_byte <= rx_msg_len;
		end else begin
			tx_byte <= rd_data;
		end
	end else if (byte_done) begin
		tx_byte <= (byte_idx == 8'h00) ? `SYNC_CTRL : `IDLE_TX;
	end
end

// output bit changes on falling edge; ninth sci bit is forced high
wire [2:0] tx_pos = msb_first ? (3'h7 - bit_cnt[2:0]) : bit_cnt[2:0];
always @(posedge mclk) begin
	if (!nrst) begin
		miso <= 1'b1;
	end else if (fall) begin
		if (bit_cnt == 4'h8) begin
			miso <= 1'b1;
		end else begin
			miso <= tx_byte[tx_pos];
		end
	end
end
assign miso_oe = sel;

////////////////////////////////////////////////////////////////////////
// write buffer: two entries so a short core stall loses nothing
reg [15:0] buf_mem [0:WR_DEPTH-1];
reg [1:0] buf_cnt;
reg buf_rp;
reg buf_wp;
wire buf_full = (buf_cnt == WR_DEPTH[1:0]);
wire buf_push = data_byte & dir_wr & ~buf_full;
wire buf_pop = wr_valid & wr_ready;
assign wr_valid = (buf_cnt != 2'h0);
assign wr_addr = buf_mem[buf_rp][15:8];
assign wr_data = buf_mem[buf_rp][7:0];

// the host cannot be stalled, so a push into a full buffer is flagged
always @(posedge mclk) begin
	if (!nrst) begin
		buf_cnt <= 2'h0;
		buf_rp <= 1'b0;
		buf_wp <= 1'b0;
		wr_drop <= 1'b0;
	end else begin
		wr_drop <= data_byte & dir_wr & buf_full;
		if (buf_push) begin
			buf_mem[buf_wp] <= {addr, rx_byte};
			buf_wp <= ~buf_wp;
		end
		if (buf_pop) begin
			buf_rp <= ~buf_rp;
		end
		if (buf_push && !buf_pop) begin
			buf_cnt <= buf_cnt + 2'h1;
		end else if (buf_pop && !buf_push) begin
			buf_cnt <= buf_cnt - 2'h1;
		end
	end
end

////////////////////////////////////////////////////////////////////////
// interrupt line: pulled low while pending, released on access
reg [3:0] rel_cnt;
wire int_access = data_byte & (addr >= `ADDR_INT_LO) &
	(addr <= `ADDR_INT_HI);
always @(posedge mclk) begin
	if (!nrst) begin
		rel_cnt <= 4'h0;
	end else if (int_access) begin
		rel_cnt <= `INT_REL_CYC;
	end else if (rel_cnt != 4'h0) begin
		rel_cnt <= rel_cnt - 4'h1;
	end
end
assign int_o = 1'b0;
assign int_oe = irq_pending & (rel_cnt == 4'h0);

////////////////////////////////////////////////////////////////////////
// internal reset: sources assert at once, release 12 cycles later
wire global_reset_cmd = buf_push & (addr == `ADDR_CMD) &
	rx_byte[`GLOBAL_RESET_CMD_BIT];
wire rst_src = ~pin_q | init_seq | global_reset_cmd;
reg [3:0] rst_cnt;
always @(posedge mclk) begin
	if (!nrst) begin
		rst_cnt <= `RST_WAIT_CYC;
	end else if (rst_src) begin
		rst_cnt <= `RST_WAIT_CYC;
	end else if (rst_cnt != 4'h0) begin
		rst_cnt <= rst_cnt - 4'h1;
	end
end
// assertion is combinational so it does not wait for an edge
assign core_rst_n = ~rst_src & (rst_cnt == 4'h0);
assign osc_en = ~core_rst_n | 1'b1; // oscillator kept on always, in reset and out of it

endmodule // serial_host_slave_port

////////////////////////////////////////////////////////////////////////
// two-flop synchroniser for one asynchronous input bit
module two_flop_sync #(
	parameter [0:0] RESET_VAL = 1'b0
) (
	input wire mclk,
	input wire nrst,
	input wire d,
	output wire q
);

// only the second flop leaves; the first may still be settling
reg [1:0] stage;
always @(posedge mclk) begin
	if (!nrst) begin
		stage <= {2{RESET_VAL}};
	end else begin
		stage <= {stage[0], d};
	end
end
assign q = stage[1];

endmodule // two_flop_sync
